//--- fstm_top.sv
// Purpose: Flash content protection gate with a read-only oscillator trim mirror.
// Assumes: Classic Wishbone slave; flash read port answers with a one-cycle ack.
// Notes: All gating except the software debug lock is fixed from the state captured after reset until the next reset.
`timescale 1ns/1ns
`default_nettype none
module fstm_top (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Boot select pins
   input wire logic [1:0] boot_select_pins,
   // Flash read port used at reset
   output logic fl_rd_req,
   output logic [31:0] fl_rd_addr,
   input wire logic fl_rd_ack,
   input wire logic [31:0] fl_rd_data,
   // Flash command requests
   input wire logic cmd_valid_i,
   input wire logic cmd_chip_erase_i,
   input wire logic cmd_from_dbg_i,
   output logic cmd_grant_o,
   output logic cmd_refuse_o,
   // Flash read data path
   input wire logic rd_valid_i,
   input wire logic rd_from_dbg_i,
   input wire logic [31:0] rd_data_i,
   output logic rd_valid_o,
   output logic [31:0] rd_data_o,
   // Debug port access enable
   output logic dbg_access_en_o
);
   logic [15:0] sec_code;
   logic [fstm_pkg::TRIM_W-1:0] trim_value_field;
   logic [1:0] boot_mode;
   logic load_done;

   fstm_boot_loader u_loader (
      .clk(clk),
      .sys_rst(sys_rst),
      .boot_select_pins(boot_select_pins),
      .fl_rd_req(fl_rd_req),
      .fl_rd_addr(fl_rd_addr),
      .fl_rd_ack(fl_rd_ack),
      .fl_rd_data(fl_rd_data),
      .sec_code(sec_code),
      .trim_value_field(trim_value_field),
      .boot_mode(boot_mode),
      .load_done(load_done)
   );

   // Gate decode from the state captured at reset.
   logic prot, restricted, allow_erase, allow_other, read_true, dbg_ok;

   always_comb begin
      prot = load_done && (sec_code == fstm_pkg::PROT_CODE);
      // Undocumented boot modes are treated like serial writer mode, the safer choice.
      restricted = prot && (boot_mode != fstm_pkg::MODE_USER);
      allow_erase = load_done && !(prot && cmd_from_dbg_i);
      allow_other = load_done && !(prot && (cmd_from_dbg_i || restricted));
      read_true = load_done && !(prot && (rd_from_dbg_i || restricted));
   end

   // Command and read gating.
   logic grant_q, grant_d, refuse_q, refuse_d, rdv_q, rdv_d, dbg_q, dbg_d;
   logic [31:0] rdd_q, rdd_d;
   logic ctrl_dbg_lock_q, ctrl_dbg_lock_d;

   always_comb begin
      grant_d = 1'b0;
      refuse_d = 1'b0;
      if (cmd_valid_i) begin
         if (cmd_chip_erase_i ? allow_erase : allow_other) begin
            grant_d = 1'b1;
         end else begin
            refuse_d = 1'b1;
         end
      end
      rdv_d = rd_valid_i;
      rdd_d = rdd_q;
      if (rd_valid_i) begin
         rdd_d = read_true ? rd_data_i : fstm_pkg::INVALID_DATA;
      end
      // Software may add a debug lock but can never open a protected part.
      dbg_ok = load_done && !prot && !ctrl_dbg_lock_q;
      dbg_d = dbg_ok;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         grant_q <= 1'b0;
         refuse_q <= 1'b0;
         rdv_q <= 1'b0;
         rdd_q <= '0;
         dbg_q <= 1'b0;
      end else begin
         grant_q <= grant_d;
         refuse_q <= refuse_d;
         rdv_q <= rdv_d;
         rdd_q <= rdd_d;
         dbg_q <= dbg_d;
      end
   end

   assign cmd_grant_o = grant_q;
   assign cmd_refuse_o = refuse_q;
   assign rd_valid_o = rdv_q;
   assign rd_data_o = rdd_q;
   assign dbg_access_en_o = dbg_q;

   // Wishbone register slave; answers every access one cycle after the strobe.
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic req;

   always_comb begin
      req = wb_cyc_i && wb_stb_i && !ack_q;
      ack_d = req;
      dat_d = dat_q;
      ctrl_dbg_lock_d = ctrl_dbg_lock_q;
      if (req && !wb_we_i) begin
         dat_d = '0;
         case (wb_adr_i)
            fstm_pkg::ADR_TRIM: begin
               // Read only in every boot mode; writes are ignored.
               dat_d[fstm_pkg::TRIM_W-1:0] = trim_value_field;
            end
            fstm_pkg::ADR_STAT: begin
               dat_d[fstm_pkg::STAT_DONE_BIT] = load_done;
               dat_d[fstm_pkg::STAT_PROT_BIT] = prot;
               dat_d[fstm_pkg::STAT_MODE_LSB +: 2] = boot_mode;
            end
            fstm_pkg::ADR_CTRL: begin
               dat_d[fstm_pkg::CTRL_DBG_LOCK_BIT] = ctrl_dbg_lock_q;
            end
            default: begin
               dat_d = '0;
            end
         endcase
      end
      // A write lands at the edge where the master sees ack, while it still holds the request.
      if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_adr_i == fstm_pkg::ADR_CTRL && wb_sel_i[0]) begin
         ctrl_dbg_lock_d = wb_dat_i[fstm_pkg::CTRL_DBG_LOCK_BIT];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         dat_q <= '0;
         ctrl_dbg_lock_q <= fstm_pkg::CTRL_RESET;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         ctrl_dbg_lock_q <= ctrl_dbg_lock_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_trim_read;
      (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i && wb_adr_i == fstm_pkg::ADR_TRIM)
         |=> wb_ack_o && wb_dat_o == {22'h0, $past(trim_value_field)};
   endproperty
   a_trim_read: assert property (p_trim_read) else $error("Trim mirror read returns wrong value.");

   property p_gates_closed_until_load;
      !load_done |=> !cmd_grant_o && !dbg_access_en_o;
   endproperty
   a_gates_closed_until_load: assert property (p_gates_closed_until_load) else $error("Gate open before load.");

   property p_prot_stable;
      load_done && $past(load_done) |-> $stable(prot) && $stable(boot_mode);
   endproperty
   a_prot_stable: assert property (p_prot_stable) else $error("Protection changed without reset.");

   property p_prot_code;
      (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i && wb_adr_i == fstm_pkg::ADR_STAT)
         |=> wb_dat_o[fstm_pkg::STAT_PROT_BIT] == ($past(load_done) && $past(sec_code) == fstm_pkg::PROT_CODE);
   endproperty
   a_prot_code: assert property (p_prot_code) else $error("Protection does not follow security code.");

   property p_user_all;
      (cmd_valid_i && load_done && !cmd_from_dbg_i && boot_mode == fstm_pkg::MODE_USER) |=> cmd_grant_o && !cmd_refuse_o;
   endproperty
   a_user_all: assert property (p_user_all) else $error("User mode command refused.");

   property p_serial_other;
      (cmd_valid_i && !cmd_chip_erase_i && prot && boot_mode == fstm_pkg::MODE_SERIAL)
         |=> cmd_refuse_o && !cmd_grant_o;
   endproperty
   a_serial_other: assert property (p_serial_other) else $error("Serial mode command not refused.");

   property p_serial_erase;
      (cmd_valid_i && cmd_chip_erase_i && !cmd_from_dbg_i && load_done) |=> cmd_grant_o;
   endproperty
   a_serial_erase: assert property (p_serial_erase) else $error("Chip erase refused.");

   property p_read_gate;
      (rd_valid_i && load_done) |=> rd_valid_o &&
         rd_data_o == ($past(read_true) ? $past(rd_data_i) : fstm_pkg::INVALID_DATA);
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("Read data gating wrong.");

   property p_dbg_block;
      prot |=> !dbg_access_en_o;
   endproperty
   a_dbg_block: assert property (p_dbg_block) else $error("Debug access open while protected.");

   property p_dbg_cmd_block;
      (prot && cmd_valid_i && cmd_from_dbg_i) |=> cmd_refuse_o && !cmd_grant_o;
   endproperty
   a_dbg_cmd_block: assert property (p_dbg_cmd_block) else $error("Debug command passed while protected.");

   property p_dbg_read_block;
      (prot && rd_valid_i && rd_from_dbg_i) |=> rd_data_o == fstm_pkg::INVALID_DATA;
   endproperty
   a_dbg_read_block: assert property (p_dbg_read_block) else $error("Debug read returned data.");

   property p_serial_read_invalid;
      (prot && rd_valid_i && boot_mode == fstm_pkg::MODE_SERIAL) |=> rd_data_o == fstm_pkg::INVALID_DATA;
   endproperty
   a_serial_read_invalid: assert property (p_serial_read_invalid) else $error("Serial mode read not invalid.");

   property p_user_read_true;
      (prot && rd_valid_i && !rd_from_dbg_i && boot_mode == fstm_pkg::MODE_USER)
         |=> rd_data_o == $past(rd_data_i);
   endproperty
   a_user_read_true: assert property (p_user_read_true) else $error("User mode read not true data.");

   property p_cmd_one_answer;
      cmd_valid_i |=> cmd_grant_o != cmd_refuse_o;
   endproperty
   a_cmd_one_answer: assert property (p_cmd_one_answer) else $error("Command not answered once.");

   property p_cmd_idle_quiet;
      !cmd_valid_i |=> !cmd_grant_o && !cmd_refuse_o;
   endproperty
   a_cmd_idle_quiet: assert property (p_cmd_idle_quiet) else $error("Command answer without request.");

   property p_read_idle_quiet;
      !rd_valid_i |=> !rd_valid_o && $stable(rd_data_o);
   endproperty
   a_read_idle_quiet: assert property (p_read_idle_quiet) else $error("Read output moved without request.");

   property p_read_early_invalid;
      (rd_valid_i && !load_done) |=> rd_valid_o && rd_data_o == fstm_pkg::INVALID_DATA;
   endproperty
   a_read_early_invalid: assert property (p_read_early_invalid) else $error("Read data before load.");

   property p_ack_answer;
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("Bus request not acknowledged.");

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("Bus ack longer than one cycle.");

   property p_lock_closes;
      ctrl_dbg_lock_q |=> !dbg_access_en_o;
   endproperty
   a_lock_closes: assert property (p_lock_closes) else $error("Debug open while locked.");

   property p_lock_write;
      (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == fstm_pkg::ADR_CTRL && wb_sel_i[0])
         |=> ctrl_dbg_lock_q == $past(wb_dat_i[fstm_pkg::CTRL_DBG_LOCK_BIT]);
   endproperty
   a_lock_write: assert property (p_lock_write) else $error("Debug lock write lost.");

   property p_stat_mode;
      (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i && wb_adr_i == fstm_pkg::ADR_STAT)
         |=> wb_dat_o[fstm_pkg::STAT_MODE_LSB +: 2] == $past(boot_mode);
   endproperty
   a_stat_mode: assert property (p_stat_mode) else $error("Status does not show the boot mode.");
endmodule
`default_nettype wire

//--- fstm_pkg.sv
// Purpose: Shared constants and types for the flash security and trim mirror block.
// Assumes: Byte addressed classic Wishbone slave with 32-bit data.
// Notes: Flash locations are byte addresses into the on-chip flash array.
`default_nettype none
package fstm_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADR_TRIM = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_CTRL = 8'h08;
   // Field layout.
   localparam int TRIM_W = 10;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_PROT_BIT = 1;
   localparam int STAT_MODE_LSB = 2;
   localparam int CTRL_DBG_LOCK_BIT = 0;
   localparam logic CTRL_RESET = 1'h0;
   // Flash locations and codes.
   localparam logic [31:0] SEC_ADDR = 32'h0010_0000;
   localparam logic [31:0] TRIM_ADDR = 32'h0010_1004;
   localparam logic [15:0] PROT_CODE = 16'h0001;
   localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
   localparam logic [31:0] INVALID_DATA = 32'h0000_0000;
   // Boot modes on the boot select pins.
   localparam logic [1:0] MODE_USER = 2'h0;
   localparam logic [1:0] MODE_SERIAL = 2'h1;
   typedef enum logic [1:0] {LD_IDLE, LD_SEC, LD_TRIM, LD_DONE} fstm_load_e;
endpackage
`default_nettype wire

//--- fstm_boot_loader.sv
// Purpose: Reads the security code and trim word from flash once after each reset.
// Assumes: Flash answers each held read request with a one-cycle ack and data.
// Notes: The request may stay high across the two reads; the address changes after the first ack.
`timescale 1ns/1ns
`default_nettype none
module fstm_boot_loader (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Boot select pins
   input wire logic [1:0] boot_select_pins,
   // Flash read port
   output logic fl_rd_req,
   output logic [31:0] fl_rd_addr,
   input wire logic fl_rd_ack,
   input wire logic [31:0] fl_rd_data,
   // Captured state
   output logic [15:0] sec_code,
   output logic [fstm_pkg::TRIM_W-1:0] trim_value_field,
   output logic [1:0] boot_mode,
   output logic load_done
);
   fstm_pkg::fstm_load_e st_q, st_d;
   logic req_q, req_d, done_q, done_d;
   logic [31:0] addr_q, addr_d;
   logic [15:0] sec_q, sec_d;
   logic [fstm_pkg::TRIM_W-1:0] trim_q, trim_d;
   logic [1:0] mode_q, mode_d;

   always_comb begin
      st_d = st_q;
      req_d = req_q;
      addr_d = addr_q;
      sec_d = sec_q;
      trim_d = trim_q;
      mode_d = mode_q;
      done_d = done_q;
      case (st_q)
         fstm_pkg::LD_IDLE: begin
            mode_d = boot_select_pins;
            req_d = 1'b1;
            addr_d = fstm_pkg::SEC_ADDR;
            st_d = fstm_pkg::LD_SEC;
         end
         fstm_pkg::LD_SEC: begin
            if (fl_rd_ack) begin
               sec_d = fl_rd_data[15:0];
               addr_d = fstm_pkg::TRIM_ADDR;
               st_d = fstm_pkg::LD_TRIM;
            end
         end
         fstm_pkg::LD_TRIM: begin
            if (fl_rd_ack) begin
               // An erased array reads all ones; the mirror then reads as cleared.
               trim_d = (fl_rd_data == fstm_pkg::ERASED_WORD) ? '0 : fl_rd_data[fstm_pkg::TRIM_W-1:0];
               req_d = 1'b0;
               done_d = 1'b1;
               st_d = fstm_pkg::LD_DONE;
            end
         end
         default: begin
            st_d = fstm_pkg::LD_DONE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= fstm_pkg::LD_IDLE;
         req_q <= 1'b0;
         addr_q <= '0;
         sec_q <= '0;
         trim_q <= '0;
         mode_q <= fstm_pkg::MODE_USER;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         addr_q <= addr_d;
         sec_q <= sec_d;
         trim_q <= trim_d;
         mode_q <= mode_d;
         done_q <= done_d;
      end
   end

   assign fl_rd_req = req_q;
   assign fl_rd_addr = addr_q;
   assign sec_code = sec_q;
   assign trim_value_field = trim_q;
   assign boot_mode = mode_q;
   assign load_done = done_q;

   property p_erased_clear;
      @(posedge clk) disable iff (sys_rst)
      (st_q == fstm_pkg::LD_TRIM && fl_rd_ack && fl_rd_data == fstm_pkg::ERASED_WORD) |=> (trim_q == '0) && done_q;
   endproperty
   a_erased_clear: assert property (p_erased_clear) else $error("Trim mirror not cleared after erased load.");

   property p_trim_load;
      @(posedge clk) disable iff (sys_rst)
      (st_q == fstm_pkg::LD_TRIM && fl_rd_ack && fl_rd_data != fstm_pkg::ERASED_WORD)
         |=> trim_q == $past(fl_rd_data[fstm_pkg::TRIM_W-1:0]);
   endproperty
   a_trim_load: assert property (p_trim_load) else $error("Trim mirror does not hold the flash trim word.");
endmodule
`default_nettype wire

//--- fstm_flash_model.sv
// Purpose: Behavioural on-chip flash that answers the reset-time read port.
// Assumes: The loader holds each request until it sees the one-cycle ack.
// Notes: Contents and answer delay come from the bench; other addresses read erased.
`timescale 1ns/1ns
`default_nettype none
module fstm_flash_model (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Contents and answer delay
   input wire logic [31:0] sec_word,
   input wire logic [31:0] trim_word,
   input wire logic [3:0] delay,
   // Flash read port
   input wire logic fl_rd_req,
   input wire logic [31:0] fl_rd_addr,
   output logic fl_rd_ack,
   output logic [31:0] fl_rd_data
);
   logic [3:0] cnt_q;
   // Outside an answer the data lines toggle, so a stale word is never taken for a fresh one.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 4'h0;
         fl_rd_ack <= 1'b0;
         fl_rd_data <= 32'h0;
      end else begin
         fl_rd_ack <= 1'b0;
         fl_rd_data <= ~fl_rd_data;
         if (fl_rd_ack) begin
            cnt_q <= 4'h0;
         end else if (fl_rd_req && cnt_q == delay) begin
            fl_rd_ack <= 1'b1;
            fl_rd_data <= (fl_rd_addr == fstm_pkg::SEC_ADDR) ? sec_word :
               (fl_rd_addr == fstm_pkg::TRIM_ADDR) ? trim_word : fstm_pkg::ERASED_WORD;
         end else if (fl_rd_req) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- test_flash_security_trim_mirror.sv
// Purpose: Self-checking bench for the flash protection gate and trim mirror.
// Assumes: Wishbone answers one cycle after it takes a request.
// Notes: Plain cases run from a table; reload, erase and register cases follow it.
`timescale 1ns/1ns
`default_nettype none
module test_flash_security_trim_mirror;
   typedef struct packed {logic [1:0] m; logic [31:0] s; logic [31:0] t; logic [3:0] d; logic p; logic [9:0] e;} fstm_row_s;
   localparam logic [31:0] RDV = 32'h5a5a_c3c3;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, dly = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, fl_addr, fl_data, rd_dout, q, saved;
   logic [31:0] sec = 32'hffff_ffff, trim = 32'h0, rd_din = 32'h0;
   logic [1:0] pins = 2'h0;
   logic fl_req, fl_ack, grant, refuse, rd_vo, dbg_en, usr;
   logic cmd_v = 1'b0, cmd_er = 1'b0, cmd_dbg = 1'b0, rd_v = 1'b0, rd_dbg = 1'b0;
   int fail_count = 0;
   int tests_run = 0;
   fstm_row_s r;
   fstm_row_s rows [6] = '{
      '{2'h0, 32'hffff_ffff, 32'h1234_5abc, 4'h0, 1'b0, 10'h2bc},
      '{2'h1, 32'hffff_ffff, 32'h0000_03ff, 4'h3, 1'b0, 10'h3ff},
      '{2'h0, 32'habcd_0001, 32'h0000_0155, 4'h1, 1'b1, 10'h155},
      '{2'h1, 32'h0000_0001, 32'h0000_0155, 4'h0, 1'b1, 10'h155},
      '{2'h2, 32'hffff_0001, 32'hffff_ffff, 4'h2, 1'b1, 10'h000},
      '{2'h3, 32'h0000_0002, 32'h7fff_fe01, 4'h0, 1'b0, 10'h201}};

   always #20 clk = ~clk;

   fstm_top DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .boot_select_pins(pins),
      .fl_rd_req(fl_req), .fl_rd_addr(fl_addr), .fl_rd_ack(fl_ack), .fl_rd_data(fl_data),
      .cmd_valid_i(cmd_v), .cmd_chip_erase_i(cmd_er), .cmd_from_dbg_i(cmd_dbg), .cmd_grant_o(grant),
      .cmd_refuse_o(refuse), .rd_valid_i(rd_v), .rd_from_dbg_i(rd_dbg), .rd_data_i(rd_din),
      .rd_valid_o(rd_vo), .rd_data_o(rd_dout), .dbg_access_en_o(dbg_en));
   fstm_flash_model flash (.clk(clk), .sys_rst(sys_rst), .sec_word(sec), .trim_word(trim), .delay(dly),
      .fl_rd_req(fl_req), .fl_rd_addr(fl_addr), .fl_rd_ack(fl_ack), .fl_rd_data(fl_data));

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic hang();
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      finish_test();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) hang();
      o = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic boot(input logic [1:0] m, input logic [31:0] s, input logic [31:0] t, input logic [3:0] d);
      @(posedge clk);
      sys_rst <= 1'b1; pins <= m; sec <= s; trim <= t; dly <= d;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      do begin wb(1'b0, fstm_pkg::ADR_STAT, 32'h0, q); n++; end while (q[0] !== 1'b1 && n < 30);
      if (q[0] !== 1'b1) hang();
   endtask
   task automatic cmd(input logic er, input logic dbg, input logic exp);
      @(posedge clk);
      cmd_v <= 1'b1; cmd_er <= er; cmd_dbg <= dbg;
      @(posedge clk);
      cmd_v <= 1'b0;
      #1 chk({30'h0, grant, refuse}, {30'h0, exp, !exp});
   endtask
   task automatic rdp(input logic dbg, input logic [31:0] exp);
      @(posedge clk);
      rd_v <= 1'b1; rd_dbg <= dbg; rd_din <= RDV;
      @(posedge clk);
      rd_v <= 1'b0;
      #1 chk({31'h0, rd_vo}, 32'h1);
      chk(rd_dout, exp);
   endtask

   initial begin
      foreach (rows[i]) begin
         r = rows[i];
         boot(r.m, r.s, r.t, r.d);
         wait_done();
         usr = (r.m == fstm_pkg::MODE_USER);
         wb(1'b0, fstm_pkg::ADR_TRIM, 32'h0, q);
         chk(q, {22'h0, r.e});
         wb(1'b0, fstm_pkg::ADR_STAT, 32'h0, q);
         chk(q, {28'h0, r.m, r.p, 1'b1});
         wb(1'b0, fstm_pkg::ADR_CTRL, 32'h0, q);
         chk(q, 32'h0);
         chk({31'h0, dbg_en}, {31'h0, !r.p});
         cmd(1'b1, 1'b0, 1'b1);
         cmd(1'b0, 1'b0, !r.p || usr);
         cmd(1'b0, 1'b1, !r.p);
         cmd(1'b1, 1'b1, !r.p);
         rdp(1'b0, (!r.p || usr) ? RDV : fstm_pkg::INVALID_DATA);
         rdp(1'b1, r.p ? fstm_pkg::INVALID_DATA : RDV);
      end
      // A slow flash keeps the gate shut until both words are in.
      boot(2'h0, 32'hffff_ffff, 32'h0000_02a5, 4'hf);
      cmd(1'b0, 1'b0, 1'b0);
      rdp(1'b0, fstm_pkg::INVALID_DATA);
      wait_done();
      wb(1'b0, fstm_pkg::ADR_TRIM, 32'h0, saved);
      sec <= {16'h0, fstm_pkg::PROT_CODE};
      wb(1'b0, fstm_pkg::ADR_STAT, 32'h0, q);
      chk({31'h0, q[1]}, 32'h0);
      boot(2'h0, {16'h0, fstm_pkg::PROT_CODE}, 32'h0000_02a5, 4'h0);
      wait_done();
      chk({30'h0, q[1], dbg_en}, 32'h2);
      cmd(1'b1, 1'b0, 1'b1);
      boot(2'h1, {16'h0, fstm_pkg::PROT_CODE}, 32'h0000_02a5, 4'h0);
      wait_done();
      cmd(1'b1, 1'b1, 1'b0);
      cmd(1'b1, 1'b0, 1'b1);
      sec <= 32'hffff_ffff;
      trim <= 32'hffff_ffff;
      wb(1'b0, fstm_pkg::ADR_STAT, 32'h0, q);
      chk({31'h0, q[1]}, 32'h1);
      boot(2'h1, 32'hffff_ffff, 32'hffff_ffff, 4'h0);
      wait_done();
      chk({30'h0, q[1], dbg_en}, 32'h1);
      wb(1'b0, fstm_pkg::ADR_TRIM, 32'h0, q);
      chk(q, 32'h0);
      chk(saved, 32'h0000_02a5);
      wb(1'b1, fstm_pkg::ADR_TRIM, 32'hffff_ffff, q);
      wb(1'b0, fstm_pkg::ADR_TRIM, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, 8'h40, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, fstm_pkg::ADR_CTRL, 32'h1, q);
      wb(1'b0, fstm_pkg::ADR_CTRL, 32'h0, q);
      chk({30'h0, q[0], dbg_en}, 32'h2);
      wb(1'b1, fstm_pkg::ADR_CTRL, 32'h0, q);
      wb(1'b0, fstm_pkg::ADR_CTRL, 32'h0, q);
      chk({30'h0, q[0], dbg_en}, 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
